// ===== hdl/qirw_ctrl.sv
`timescale 1ns/1ps
// ==========================================
// prefetch fifo between array and pin shifter
module qirw_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input  wire logic         i_clk,
  input  wire logic         i_arst_n,
  input  wire logic         i_flush,     // drop all content
  input  wire logic         i_in_valid,
  output logic              o_in_ready,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_out_valid,
  input  wire logic         i_out_ready,
  output logic [W-1:0]      o_out_data
);
  localparam int AW = $clog2(D);

  // pointers wrap naturally, so depth must be a power of two
  if (D < 2 || (1 << AW) != D) begin : g_chk
    $error("qirw_fifo depth must be a power of two");
  end

  typedef struct packed {
    logic [D-1:0][W-1:0] mem; // storage words
    logic [AW-1:0]       rd;  // read pointer
    logic [AW-1:0]       wr;  // write pointer
    logic [AW:0]         cnt; // fill level
  } qirw_fifo_s;

  qirw_fifo_s s_r;
  qirw_fifo_s s_nxt;
  logic       push;
  logic       pop;

  assign o_in_ready  = (s_r.cnt != (AW+1)'(D));
  assign o_out_valid = (s_r.cnt != '0);
  assign o_out_data  = s_r.mem[s_r.rd];

  // ==========================================
  // next state
  always_comb begin
    s_nxt = s_r;
    push  = i_in_valid & o_in_ready;
    pop   = i_out_ready & o_out_valid;
    if (i_flush) begin
      // flush wins over any traffic in the same cycle
      s_nxt.rd  = '0;
      s_nxt.wr  = '0;
      s_nxt.cnt = '0;
    end else begin
      if (push) begin
        s_nxt.mem[s_r.wr] = i_in_data;
        s_nxt.wr          = s_r.wr + 1'b1;
      end
      if (pop) begin
        s_nxt.rd = s_r.rd + 1'b1;
      end
      s_nxt.cnt = s_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // ==========================================
  // state register
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule

// ==========================================
// quad read, wrap and continuous mode control
module qirw_ctrl #(
  parameter int FW = qirw_pkg::FIFO_WIDTH,
  parameter int FD = qirw_pkg::FIFO_DEPTH
) (
  input  wire logic        i_clk,
  input  wire logic        i_arst_n,
  input  wire logic        i_sclk,        // serial clock pin
  input  wire logic        i_cs_n,        // chip select pin
  input  wire logic [3:0]  i_io,          // data pins, input side
  output logic [3:0]       o_io_out,      // data pins, drive value
  output logic [3:0]       o_io_oe,       // data pins, drive enable
  input  wire logic        i_quad_io_enable_bit,
  input  wire logic        i_four_wire_command_mode,
  output logic             o_mem_req,     // array read strobe
  output logic [23:0]      o_mem_addr,    // array read address
  input  wire logic [7:0]  i_mem_data,    // array byte at o_mem_addr
  output logic [2:0]       o_wrap_setting_bits,
  output logic [7:0]       o_continuous_mode_byte,
  output logic [3:0]       o_read_dummy_clocks
);
  if (FW != 8 || FD < 4) begin : g_chk
    $error("qirw_ctrl needs byte wide fifo of depth 4 or more");
  end

  typedef struct packed {
    logic                  cs1;    // synchroniser stages
    logic                  cs2;
    logic                  ck1;
    logic                  ck2;
    logic                  ck3;    // previous synced clock
    logic [3:0]            io1;
    logic [3:0]            io2;
    qirw_pkg::qirw_state_e st;     // frame phase
    logic [7:0]            cmd;    // current command opcode
    logic [3:0]            cnt;    // clocks within phase
    logic [3:0]            dum;    // dummy clocks of this read
    logic [31:0]           sh;     // input shifter
    logic [23:0]           fa;     // fetch address
    logic                  fetch;  // array fetch running
    logic                  wact;   // wrap applies to this read
    logic [7:0]            wmask;  // wrap section mask
    logic [2:0]            wrap;   // wrap setting bits
    logic [1:0]            psel;   // dummy select
    logic [3:0]            mode;   // upper mode nibble
    logic                  cont;   // opcode skip armed
    logic                  rsten;  // reset enable seen
    logic                  rstarm; // reset waits for deselect
    logic                  nib;    // low nibble is next
    logic [3:0]            lo;     // held low nibble
    logic [3:0]            dout;   // pin drive value
    logic                  oe;     // pins driven
  } qirw_ctrl_s;

  qirw_ctrl_s  s_r;
  qirw_ctrl_s  s_nxt;
  logic        rise;       // serial clock rising edge
  logic        fall;       // serial clock falling edge
  logic [31:0] shq;        // nibble shifted in
  logic [31:0] shs;        // single bit shifted in
  logic [7:0]  op;         // finished opcode byte
  logic [3:0]  dsel;       // chosen dummy count
  logic        pop;
  logic        f_ready;
  logic        f_valid;
  logic [7:0]  f_data;
  logic [23:0] inc;        // fetch address plus one
  logic [23:0] m24;        // wrap mask, full width

  // ==========================================
  // prefetch buffer
  qirw_fifo #(
    .W (FW),
    .D (FD)
  ) u_fifo (
    .i_clk       (i_clk),
    .i_arst_n    (i_arst_n),
    .i_flush     (s_r.cs2),
    .i_in_valid  (s_r.fetch),
    .o_in_ready  (f_ready),
    .i_in_data   (i_mem_data),
    .o_out_valid (f_valid),
    .i_out_ready (pop),
    .o_out_data  (f_data)
  );

  assign o_io_out               = s_r.dout;
  assign o_io_oe                = {4{s_r.oe}};
  // a full fifo stalls the array fetch
  assign o_mem_req              = s_r.fetch & f_ready;
  assign o_mem_addr             = s_r.fa;
  assign o_wrap_setting_bits    = s_r.wrap;
  assign o_continuous_mode_byte = {s_r.mode, 4'h0};
  assign o_read_dummy_clocks    = qirw_pkg::fw_dummy(s_r.psel) + qirw_pkg::MODE_CLK;

  // ==========================================
  // next state: sync, frame decode, fetch, output
  always_comb begin
    s_nxt     = s_r;
    s_nxt.cs1 = i_cs_n;
    s_nxt.cs2 = s_r.cs1;
    s_nxt.ck1 = i_sclk;
    s_nxt.ck2 = s_r.ck1;
    s_nxt.ck3 = s_r.ck2;
    s_nxt.io1 = i_io;
    s_nxt.io2 = s_r.io1;
    rise = s_r.ck2 & ~s_r.ck3;
    fall = ~s_r.ck2 & s_r.ck3;
    shq  = {s_r.sh[27:0], s_r.io2};
    shs  = {s_r.sh[30:0], s_r.io2[0]};
    op   = i_four_wire_command_mode ? shq[7:0] : shs[7:0];
    pop  = 1'b0;
    inc  = s_r.fa + 24'h000001;
    m24  = {16'h0000, s_r.wmask};
    // per-command dummy clocks
    if (s_r.cmd == qirw_pkg::OP_WORD_READ) begin
      dsel = qirw_pkg::DUM_WORD;
    end else if (s_r.cmd == qirw_pkg::OP_OCTAL_READ) begin
      dsel = qirw_pkg::DUM_OCTAL;
    end else if (i_four_wire_command_mode) begin
      dsel = qirw_pkg::fw_dummy(s_r.psel);
    end else begin
      dsel = qirw_pkg::DUM_QUAD;
    end
    // array fetch, one byte per accepted cycle
    if (s_r.fetch && f_ready) begin
      if (s_r.wact) begin
        s_nxt.fa = (s_r.fa & ~m24) | (inc & m24);
      end else begin
        s_nxt.fa = inc;
      end
    end
    if (s_r.cs2) begin
      // deselected: a pending reset runs at the rising select
      if (s_r.rstarm && !s_r.cont) begin
        s_nxt.wrap = qirw_pkg::WRAP_DEFAULT;
        s_nxt.psel = qirw_pkg::DUM_SEL_DEFAULT;
      end
      s_nxt.st     = qirw_pkg::ST_IDLE;
      s_nxt.fetch  = 1'b0;
      s_nxt.oe     = 1'b0;
      s_nxt.rstarm = 1'b0;
      s_nxt.nib    = 1'b0;
      s_nxt.cnt    = 4'h0;
    end else begin
      unique case (s_r.st)
        qirw_pkg::ST_IDLE: begin
          // frame start: skip opcode when armed
          if (s_r.cont) begin
            s_nxt.st    = qirw_pkg::ST_ADDR;
            s_nxt.rsten = 1'b0;
          end else begin
            s_nxt.st = qirw_pkg::ST_OPC;
          end
        end
        qirw_pkg::ST_OPC: begin
          if (rise) begin
            s_nxt.sh  = i_four_wire_command_mode ? shq : shs;
            s_nxt.cnt = s_r.cnt + 4'h1;
            if (s_r.cnt == (i_four_wire_command_mode ? qirw_pkg::OPC_CLK_NIB : qirw_pkg::OPC_CLK_SER) - 4'h1) begin
              s_nxt.cnt   = 4'h0;
              s_nxt.st    = qirw_pkg::ST_SKIP;
              s_nxt.cmd   = op;
              // any command but reset enable clears the enable
              s_nxt.rsten = (op == qirw_pkg::OP_RST_ENABLE);
              unique case (op)
                qirw_pkg::OP_QUAD_READ, qirw_pkg::OP_WORD_READ, qirw_pkg::OP_OCTAL_READ: begin
                  if (i_quad_io_enable_bit) begin
                    s_nxt.st = qirw_pkg::ST_ADDR;
                  end
                end
                qirw_pkg::OP_SET_WRAP: begin
                  if (i_quad_io_enable_bit) begin
                    s_nxt.st = qirw_pkg::ST_ARG;
                  end
                end
                qirw_pkg::OP_SET_PARAM: begin
                  if (i_four_wire_command_mode) begin
                    s_nxt.st = qirw_pkg::ST_ARG;
                  end
                end
                qirw_pkg::OP_MODE_RST: begin
                  s_nxt.mode = 4'h0;
                  s_nxt.cont = 1'b0;
                end
                qirw_pkg::OP_RST_EXEC: begin
                  s_nxt.rstarm = s_r.rsten;
                end
                default: begin
                  // unknown or out-of-scope command, ignored
                end
              endcase
            end
          end
        end
        qirw_pkg::ST_ADDR: begin
          if (rise) begin
            s_nxt.sh  = shq;
            s_nxt.cnt = s_r.cnt + 4'h1;
            if (s_r.cnt == qirw_pkg::ADDR_CLK - 4'h1) begin
              // fetch starts early to hide array latency
              s_nxt.fa    = shq[23:0];
              s_nxt.fetch = 1'b1;
              s_nxt.cnt   = 4'h0;
              s_nxt.st    = qirw_pkg::ST_MODE;
              s_nxt.wact  = ~s_r.wrap[0] & ~i_four_wire_command_mode &
                            (s_r.cmd != qirw_pkg::OP_OCTAL_READ);
              s_nxt.wmask = (qirw_pkg::WRAP_BASE << s_r.wrap[2:1]) - 8'h01;
            end
          end
        end
        qirw_pkg::ST_MODE: begin
          if (rise) begin
            s_nxt.sh  = shq;
            s_nxt.cnt = s_r.cnt + 4'h1;
            if (s_r.cnt == qirw_pkg::MODE_CLK - 4'h1) begin
              // low nibble dropped on purpose
              s_nxt.mode = shq[7:4];
              s_nxt.cont = (shq[qirw_pkg::SKIP_LO +: 2] == qirw_pkg::SKIP_CODE);
              s_nxt.cnt  = 4'h0;
              s_nxt.dum  = dsel;
              s_nxt.st   = (dsel == 4'h0) ? qirw_pkg::ST_DATA : qirw_pkg::ST_DUMMY;
              // pins stay released until the first data fall
            end
          end
        end
        qirw_pkg::ST_DUMMY: begin
          if (rise) begin
            s_nxt.cnt = s_r.cnt + 4'h1;
            if (s_r.cnt == s_r.dum - 4'h1) begin
              s_nxt.st = qirw_pkg::ST_DATA;
            end
          end
        end
        qirw_pkg::ST_DATA: begin
          // high nibble first; an empty fifo repeats stale data
          if (fall) begin
            // drive from the first fall only, so the host has let go
            s_nxt.oe = 1'b1;
            if (!s_r.nib) begin
              pop        = 1'b1;
              s_nxt.dout = f_data[7:4];
              s_nxt.lo   = f_data[3:0];
              s_nxt.nib  = 1'b1;
            end else begin
              s_nxt.dout = s_r.lo;
              s_nxt.nib  = 1'b0;
            end
          end
        end
        qirw_pkg::ST_ARG: begin
          if (rise) begin
            s_nxt.sh  = shq;
            s_nxt.cnt = s_r.cnt + 4'h1;
            if (s_r.cmd == qirw_pkg::OP_SET_WRAP && s_r.cnt == qirw_pkg::WRAP_ARG_CLK - 4'h1) begin
              s_nxt.wrap = shq[qirw_pkg::WRAP_ARG_LO +: 3];
              s_nxt.st   = qirw_pkg::ST_SKIP;
            end else if (s_r.cmd == qirw_pkg::OP_SET_PARAM && s_r.cnt == qirw_pkg::PARAM_CLK - 4'h1) begin
              s_nxt.psel      = shq[qirw_pkg::PARAM_DUM_LO +: 2];
              s_nxt.wrap[2:1] = shq[qirw_pkg::PARAM_LEN_LO +: 2];
              s_nxt.st        = qirw_pkg::ST_SKIP;
            end
          end
        end
        qirw_pkg::ST_SKIP: begin
          // wait for deselect
        end
      endcase
    end
  end

  // ==========================================
  // state register
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s_r      <= '0;
      s_r.cs1  <= 1'b1;
      s_r.cs2  <= 1'b1;
      s_r.wrap <= qirw_pkg::WRAP_DEFAULT;
      s_r.psel <= qirw_pkg::DUM_SEL_DEFAULT;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule

// ===== hdl/qirw_pkg.sv
// What this block does
// - wrap restarts at aligned section start until deselect
// - wrap sections stay aligned inside 256-byte page
// - wrap command: opcode, 24 ignored, eight wrap bits
// - wrap disable bit: 0 wraps, 1 default off
// - length field selects 8, 16, 32, 64 bytes
// - stored wrap applies to later quad reads
// - quad commands need quad io enable bit
// - four-wire quad read dummies 4,4,6,8 default 4
// - four-wire mode byte counts toward dummies
// - four-wire quad read never wraps
// - wrap length kept, settable by parameter command
// - word read: even address, two dummies
// - octal word read: aligned address, no dummies
// - skip code 10 drops next opcode byte
// - other skip codes restore full opcode decoding
// - low nibble of continuous mode byte ignored
// - software reset leaves continuous mode alone
// - mode reset command clears continuous mode byte
// - software reset ignored in continuous mode
// - software reset restores wrap and parameter defaults
package qirw_pkg;
  // ==========================================
  // opcodes
  localparam logic [7:0] OP_QUAD_READ  = 8'hEB;
  localparam logic [7:0] OP_WORD_READ  = 8'hE7;
  localparam logic [7:0] OP_OCTAL_READ = 8'hE3;
  localparam logic [7:0] OP_SET_WRAP   = 8'h77;
  localparam logic [7:0] OP_SET_PARAM  = 8'hC0;
  localparam logic [7:0] OP_RST_ENABLE = 8'h66;
  localparam logic [7:0] OP_RST_EXEC   = 8'h99;
  localparam logic [7:0] OP_MODE_RST   = 8'hFF;
  // ==========================================
  // fields and reset values
  localparam logic [2:0] WRAP_DEFAULT   = 3'h7; // disabled, 64 bytes
  localparam int         WRAP_ARG_LO    = 4;    // bits 6:4 of wrap byte
  localparam int         PARAM_DUM_LO   = 4;    // dummy select bits 5:4
  localparam int         PARAM_LEN_LO   = 0;    // wrap length bits 1:0
  localparam logic [1:0] DUM_SEL_DEFAULT = 2'h0;
  localparam logic [1:0] SKIP_CODE      = 2'h2;
  localparam int         SKIP_LO        = 4;
  localparam logic [7:0] WRAP_BASE      = 8'h08;
  // ==========================================
  // phase lengths in serial clocks, then fifo width and depth
  localparam logic [3:0] OPC_CLK_SER  = 4'h8;
  localparam logic [3:0] OPC_CLK_NIB  = 4'h2;
  localparam logic [3:0] ADDR_CLK     = 4'h6;
  localparam logic [3:0] MODE_CLK     = 4'h2;
  localparam logic [3:0] WRAP_ARG_CLK = 4'h8;
  localparam logic [3:0] PARAM_CLK    = 4'h2;
  localparam logic [3:0] DUM_QUAD     = 4'h4;
  localparam logic [3:0] DUM_WORD     = 4'h2;
  localparam logic [3:0] DUM_OCTAL    = 4'h0;
  localparam int         FIFO_WIDTH   = 8;
  localparam int         FIFO_DEPTH   = 16;
  // four-wire quad read dummies, mode byte already counted
  function automatic logic [3:0] fw_dummy(input logic [1:0] sel);
    logic [3:0] d;
    d = (sel == 2'h2) ? 4'h6 : ((sel == 2'h3) ? 4'h8 : 4'h4);
    return d - MODE_CLK;
  endfunction
  // ==========================================
  // frame states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_OPC   = 3'b001,
    ST_ADDR  = 3'b010,
    ST_MODE  = 3'b011,
    ST_DUMMY = 3'b100,
    ST_DATA  = 3'b101,
    ST_ARG   = 3'b110,
    ST_SKIP  = 3'b111
  } qirw_state_e;
endpackage

// ===== verification/qirw_host.sv
`timescale 1ns/1ps
// ==========================================
// host controller model, mode 0 serial clock
module qirw_host (
  input  wire logic       i_clk,
  input  wire logic [3:0] i_io,       // resolved pin level
  output logic            o_sclk,
  output logic            o_cs_n,
  output logic [3:0]      o_drv,
  output logic            o_en,       // host drives the pins
  output logic            o_byte_vld, // one clk per read byte
  output logic [7:0]      o_byte
);
  logic [3:0] smp; // nibble seen at the last rise
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_drv = 4'h0;
    o_en = 1'b0;
    o_byte_vld = 1'b0;
    o_byte = 8'h00;
  end
  // one serial clock; halves of 8 clk keep the synchronisers happy
  task automatic tick(input logic [3:0] n, input logic en);
    o_drv = n;
    o_en = en;
    repeat (8) @(negedge i_clk);
    o_sclk = 1'b1;
    smp = i_io;
    repeat (8) @(negedge i_clk);
    o_sclk = 1'b0;
  endtask
  // om: 0 opcode skipped, 1 serial on io0, 2 two nibbles
  task automatic frame(input logic [7:0] op, input int om, input logic [23:0] a, input int na,
                       input logic [7:0] m, input int nm, input int dum, input int nb);
    logic [3:0] hi;
    o_cs_n = 1'b0;
    repeat (2) @(negedge i_clk);
    if (om == 1) for (int i = 7; i >= 0; i--) tick({3'h7, op[i]}, 1'b1);
    if (om == 2) begin
      tick(op[7:4], 1'b1);
      tick(op[3:0], 1'b1);
    end
    for (int i = na - 1; i >= 0; i--) tick(a[i*4 +: 4], 1'b1);
    for (int i = nm - 1; i >= 0; i--) tick(m[i*4 +: 4], 1'b1);
    // let go before the first data fall
    o_en = 1'b0;
    repeat (dum) tick(4'h0, 1'b0);
    for (int b = 0; b < nb; b++) begin
      tick(4'h0, 1'b0);
      hi = smp;
      tick(4'h0, 1'b0);
      o_byte = {hi, smp};
      o_byte_vld = 1'b1;
      @(negedge i_clk);
      o_byte_vld = 1'b0;
    end
    o_cs_n = 1'b1;
    repeat (8) @(negedge i_clk);
  endtask
endmodule

// ===== verification/qirw_props.sv
`timescale 1ns/1ps
// ==========================================
// pin and setting checks on the top ports
module qirw_props (
  input wire logic        i_clk,
  input wire logic        i_arst_n,
  input wire logic        i_cs_n,
  input wire logic        i_quad_io_enable_bit,
  input wire logic [3:0]  o_io_oe,
  input wire logic        o_mem_req,
  input wire logic [23:0] o_mem_addr,
  input wire logic [2:0]  o_wrap_setting_bits,
  input wire logic [7:0]  o_continuous_mode_byte,
  input wire logic [3:0]  o_read_dummy_clocks
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  // deselect seen long enough to pass the pin synchronisers
  sequence s_cs_idle;
    i_cs_n [*6];
  endsequence
  // device starts driving the pins
  sequence s_oe_start;
    !o_io_oe[0] ##1 o_io_oe[0];
  endsequence
  // two back-to-back array fetches with wrapping off
  sequence s_step;
    (o_mem_req && o_wrap_setting_bits[0] && !i_cs_n) ##1 (o_mem_req && !i_cs_n);
  endsequence
  chk_oe_uniform: assert property (o_io_oe == 4'h0 || o_io_oe == 4'hF)
    else $error("pin enables differ");
  chk_oe_idle_off: assert property (s_cs_idle |-> o_io_oe == 4'h0)
    else $error("pins driven while deselected");
  chk_oe_start_ok: assert property (s_oe_start |-> !i_cs_n && i_quad_io_enable_bit)
    else $error("drive started without select or quad enable");
  chk_qe_low_quiet: assert property (!i_quad_io_enable_bit [*8] |-> o_io_oe == 4'h0)
    else $error("pins driven with quad enable low");
  chk_mode_nibble: assert property (o_continuous_mode_byte[3:0] == 4'h0)
    else $error("mode byte low nibble kept");
  chk_dummy_legal: assert property (o_read_dummy_clocks inside {4'h4, 4'h6, 4'h8})
    else $error("dummy count out of set");
  chk_mode_idle_hold: assert property (s_cs_idle |=> $stable(o_continuous_mode_byte))
    else $error("mode byte moved while idle");
  chk_cfg_idle_hold: assert property (s_cs_idle |=> $stable(o_wrap_setting_bits))
    else $error("wrap bits moved while idle");
  chk_addr_step: assert property (s_step |-> o_mem_addr == $past(o_mem_addr) + 24'h1)
    else $error("address did not step by one");
endmodule

bind qirw_ctrl qirw_props chk_u (
  .i_clk                  (i_clk),
  .i_arst_n               (i_arst_n),
  .i_cs_n                 (i_cs_n),
  .i_quad_io_enable_bit   (i_quad_io_enable_bit),
  .o_io_oe                (o_io_oe),
  .o_mem_req              (o_mem_req),
  .o_mem_addr             (o_mem_addr),
  .o_wrap_setting_bits    (o_wrap_setting_bits),
  .o_continuous_mode_byte (o_continuous_mode_byte),
  .o_read_dummy_clocks    (o_read_dummy_clocks)
);

// ===== verification/quad_io_read_wrap_control_tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
// ==========================================
// bench: host model on the pins, array as a function
module quad_io_read_wrap_control_tb;
  logic        clk = 1'b0;
  logic        arst_n, qe, fw, sclk, cs_n, h_en, h_vld, mem_req;
  logic [3:0]  io_w, io_o, oe, h_drv, dum_o;
  logic [7:0]  h_byte, mem_d, mode_o, e;
  logic [23:0] mem_a;
  logic [2:0]  wrap_o;
  logic        cs_q = 1'b1;  // chip select one clock ago
  int          req_n = 0;    // array fetches since select fell
  logic [7:0]  exp_q[$]; // expected read bytes, oldest first
  int          num_errors = 0;
  int          num_checks = 0;
  always #2 clk = ~clk;
  // pins pulled up when nobody drives
  assign io_w = (oe & io_o) | (~oe & (h_en ? h_drv : 4'hF));
  function automatic logic [7:0] mem_f(input logic [23:0] a);
    return a[7:0] ^ a[15:8];
  endfunction
  assign mem_d = mem_f(mem_a);
  qirw_ctrl dut_u (.i_clk(clk), .i_arst_n(arst_n), .i_sclk(sclk), .i_cs_n(cs_n), .i_io(io_w),
    .o_io_out(io_o), .o_io_oe(oe), .i_quad_io_enable_bit(qe), .i_four_wire_command_mode(fw),
    .o_mem_req(mem_req), .o_mem_addr(mem_a), .i_mem_data(mem_d), .o_wrap_setting_bits(wrap_o),
    .o_continuous_mode_byte(mode_o), .o_read_dummy_clocks(dum_o));
  qirw_host host_u (.i_clk(clk), .i_io(io_w), .o_sclk(sclk), .o_cs_n(cs_n), .o_drv(h_drv),
    .o_en(h_en), .o_byte_vld(h_vld), .o_byte(h_byte));
  task end_sim;
    if (num_errors == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // each captured byte meets the oldest note
  always @(posedge clk) begin
    if (h_vld === 1'b1) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hXX;
      `CHK("read byte", e, h_byte)
    end
  end
  // count array fetches of the running frame; held after deselect
  always @(posedge clk) begin
    cs_q  <= cs_n;
    req_n <= (cs_q && !cs_n) ? 0 : req_n + int'(mem_req === 1'b1);
  end
  // note the bytes a read should return, then run it
  task automatic rd(input logic [7:0] op, input int om, input logic [23:0] a, input logic [7:0] m,
                    input int dum, input int nb, input int wl);
    logic [23:0] x;
    for (int i = 0; i < nb; i++) begin
      x = a + 24'(i);
      if (wl > 0) x = (a & ~24'(wl - 1)) | (x & 24'(wl - 1));
      exp_q.push_back(mem_f(x));
    end
    host_u.frame(op, om, a, 6, m, 2, dum, nb);
  endtask
  // command frame with no data; address bits are don't-care
  task automatic cmd(input logic [7:0] op, input int om, input int na, input logic [7:0] m, input int nm);
    host_u.frame(op, om, 24'($urandom), na, m, nm, 0, 0);
  endtask
  initial begin
    logic [7:0]  w;
    logic [23:0] a;
    int          len, dd;
    arst_n = 1'b0;
    qe = 1'b1;
    fw = 1'b0;
    void'($urandom(32'hDC4BCA9A));
    repeat (16) @(negedge clk);
    arst_n = 1'b1;
    repeat (4) @(negedge clk);
    `CHK("wrap bits", 3'h7, wrap_o)
    `CHK("dummies", 4'h4, dum_o)
    rd(8'hEB, 1, 24'($urandom), 8'h00, 4, 40, 0);
    // quad enable low: read and wrap command ignored
    qe = 1'b0;
    repeat (2) exp_q.push_back(8'hFF);
    host_u.frame(8'hEB, 1, 24'($urandom), 6, 8'h00, 2, 4, 2);
    cmd(8'h77, 1, 6, 8'h00, 2);
    `CHK("wrap refused", 3'h7, wrap_o)
    qe = 1'b1;
    // every wrap length; junk in unused wrap bits
    for (len = 0; len < 4; len++) begin
      w = {1'($urandom), 2'(len), 1'b0, 4'($urandom)};
      cmd(8'h77, 1, 6, w, 2);
      `CHK("wrap set", {2'(len), 1'b0}, wrap_o)
      a = 24'($urandom);
      rd(8'hEB, 1, a, 8'h00, 4, (8 << len) + 3, 8 << len);
      rd(8'hE7, 1, a & ~24'h1, 8'h00, 2, (8 << len) + 2, 8 << len);
      rd(8'hE3, 1, a & ~24'hF, 8'h00, 0, 20, 0);
    end
    // four-wire mode: dummy select, length via parameter, no wrap
    fw = 1'b1;
    for (len = 0; len < 4; len++) begin
      dd = (len == 3) ? 8 : (len == 2) ? 6 : 4;
      cmd(8'hC0, 2, 0, {2'($urandom), 2'(len), 2'($urandom), 2'(3 - len)}, 2);
      `CHK("dummy count", 4'(dd), dum_o)
      `CHK("length via param", {2'(3 - len), 1'b0}, wrap_o)
      rd(8'hEB, 2, 24'($urandom), 8'h00, dd - 2, 12, 0);
    end
    fw = 1'b0;
    // continuous mode: arm, skip opcode, reset ignored, leave
    rd(8'hEB, 1, 24'($urandom), 8'hA5, 4, 3, 8);
    `CHK("mode byte", 8'hA0, mode_o)
    rd(8'h00, 0, 24'($urandom), {4'h2, 4'($urandom)}, 4, 3, 8);
    cmd(8'h66, 1, 0, 8'h00, 0);
    cmd(8'h99, 1, 0, 8'h00, 0);
    `CHK("wrap kept", 3'h0, wrap_o)
    cmd(8'hFF, 1, 0, 8'h00, 0);
    `CHK("skip left", 1'b0, mode_o[5:4] == 2'h2)
    // other codes need the opcode again; reset keeps mode byte
    rd(8'hEB, 1, 24'($urandom), 8'h3C, 4, 3, 8);
    rd(8'hEB, 1, 24'($urandom), 8'h30, 4, 3, 8);
    cmd(8'h66, 1, 0, 8'h00, 0);
    cmd(8'h99, 1, 0, 8'h00, 0);
    `CHK("wrap reset", 3'h7, wrap_o)
    `CHK("dummy reset", 4'h4, dum_o)
    `CHK("mode kept", 8'h30, mode_o)
    // buffer through the top: host parks after the mode byte; the second
    // frame only refills if deselect flushed the first fill
    a = 24'($urandom);
    repeat (2) begin
      host_u.frame(8'hEB, 1, a, 6, 8'h00, 2, 0, 0);
      `CHK("fifo fill", 16, req_n)
      `CHK("fetch address", a + 24'h000010, mem_a)
      `CHK("pins released", 4'h0, oe)
      `CHK("fetch stopped", 1'b0, mem_req)
    end
    `CHK("notes left", 0, exp_q.size())
    end_sim();
  end
  // hang guard
  initial begin
    repeat (95000) @(posedge clk);
    num_errors++;
    end_sim();
  end
endmodule
